// file: hw/retry_timer.sv
// interval timer: 2^code units of a programmable cycle count
`timescale 1ns/100ps
module retry_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [2:0] code_in,
  input wire logic [15:0] unit_cycles_in,
  output logic done_out,
  output logic busy_out
);
  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  logic [15:0] cyc_r;
  logic [7:0] units_r;
  logic [7:0] last_r;
  logic [15:0] unit_len;
  logic unit_end;
  logic all_end;

  assign unit_len = (unit_cycles_in == 16'h0000) ? 16'h0001 : unit_cycles_in;
  assign unit_end = busy_out && (cyc_r + 16'h0001 >= unit_len);
  assign all_end = unit_end && (units_r == last_r);
  assign done_out = all_end;

  always_ff @(posedge clk_in) begin
    if (rst_in || start_in) begin
      cyc_r <= 16'h0000;
      units_r <= 8'h00;
    end else if (unit_end) begin
      cyc_r <= 16'h0000;
      units_r <= units_r + 8'h01;
    end else if (busy_out) begin
      cyc_r <= cyc_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      last_r <= 8'h00;
    end else if (start_in) begin
      busy_out <= 1'b1;
      last_r <= 8'((9'h001 << code_in) - 9'h001); // [R16]
    end else if (all_end) begin
      busy_out <= 1'b0; // [R13]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_start_loads_span: assert property (@(posedge clk_in) disable iff (rst_in) // [R16]
    start_in |=> busy_out && last_r == 8'(($past(9'h001 << code_in)) - 9'h001))
    else $error("timer span not loaded from code");
  a_unit_one_done: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
    start_in && code_in == 3'h0 && unit_cycles_in == 16'h0001 |=> done_out)
    else $error("one-unit interval not ended after one cycle");
endmodule

// file: hw/temp_limit_bank.sv
// temperature limit registers and cold fault reaction engine
`timescale 1ns/100ps
// Contract
// R1: hot warning threshold, 16-bit linear, host read and write.
// R2: cold warning threshold, 16-bit linear, host read and write.
// R3: cold fault threshold, 16-bit linear, host read and write.
// R4: reaction byte: selector 7:6, retries 5:3, delay 2:0.
// R5: selector 00 keeps regulating through a cold fault.
// R6: selector 01 runs for the delay, then follows retries if fault stays.
// R7: selector 10 disables output at once, then follows retries.
// R8: selector 11 disables output until the latched fault is cleared.
// R9: status clear, clear-faults, reset or off-then-on clears a latch.
// R10: retries 000 means no restart; output off until cleared.
// R11: retries 001 gives one restart, then off until cleared.
// R12: retries 010 gives two restarts, then off until cleared.
// R13: restart spacing is delay count times the time unit.
// R14: retries 011 to 110 give three to six restarts, then off.
// R15: retries 111 restart forever until off command or other shutdown.
// R16: delay codes 0 to 7 mean 1 to 128 units; unit set elsewhere.
// R17: cold fault below fault limit; warnings beyond either warning limit.
// R18: each warning or fault sets a sticky status bit until cleared.
module temp_limit_bank (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] CMD_CODE_IN,
  input wire logic CMD_WR_IN,
  input wire logic [15:0] CMD_WDATA_IN,
  output logic [15:0] CMD_RDATA_OUT,
  input wire logic CLEAR_FAULTS_IN,
  input wire temp_limit_pkg::status_s STATUS_CLR_IN,
  input wire logic OUTPUT_ON_IN,
  input wire logic OTHER_SHUTDOWN_IN,
  input wire logic [15:0] TEMP_IN,
  input wire logic [15:0] TIME_UNIT_IN,
  output temp_limit_pkg::status_s STATUS_OUT,
  output logic OUTPUT_ENABLE_OUT,
  output logic FAULT_LATCHED_OUT,
  output logic RETRYING_OUT
);
  // ---------------------------------------------------------------
  // linear format to fixed point
  // ---------------------------------------------------------------
  function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
    logic signed [47:0] m;
    logic [4:0] sh;
    m = {{37{v[10]}}, v[10:0]};
    sh = {~v[15], v[14:11]};
    lin_fix = m <<< sh;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] hot_warn_r;
  logic [15:0] cold_warn_r;
  logic [15:0] cold_fault_r;
  logic [7:0] reaction_r;
  temp_limit_pkg::status_s status_r;
  temp_limit_pkg::react_e state_r;
  temp_limit_pkg::react_e state_nxt;
  logic [2:0] attempts_r;
  logic [2:0] attempts_nxt;
  logic on_d_r;
  logic en_r;
  logic tstart;

  wire wr_hot = CMD_WR_IN && CMD_CODE_IN == temp_limit_pkg::CODE_HOT_WARN;
  wire wr_cold = CMD_WR_IN && CMD_CODE_IN == temp_limit_pkg::CODE_COLD_WARN;
  wire wr_fault = CMD_WR_IN && CMD_CODE_IN == temp_limit_pkg::CODE_COLD_FAULT;
  wire wr_react = CMD_WR_IN && CMD_CODE_IN == temp_limit_pkg::CODE_REACTION;

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      hot_warn_r <= temp_limit_pkg::HOT_WARN_RST;
      cold_warn_r <= temp_limit_pkg::COLD_WARN_RST;
      cold_fault_r <= temp_limit_pkg::COLD_FAULT_RST;
      reaction_r <= temp_limit_pkg::REACTION_RST;
    end else begin
      if (wr_hot) hot_warn_r <= CMD_WDATA_IN; // [R1]
      if (wr_cold) cold_warn_r <= CMD_WDATA_IN; // [R2]
      if (wr_fault) cold_fault_r <= CMD_WDATA_IN; // [R3]
      if (wr_react) reaction_r <= CMD_WDATA_IN[7:0]; // [R4]
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  wire [15:0] rd_mux =
    (CMD_CODE_IN == temp_limit_pkg::CODE_HOT_WARN) ? hot_warn_r :
    (CMD_CODE_IN == temp_limit_pkg::CODE_COLD_WARN) ? cold_warn_r :
    (CMD_CODE_IN == temp_limit_pkg::CODE_COLD_FAULT) ? cold_fault_r :
    (CMD_CODE_IN == temp_limit_pkg::CODE_REACTION) ? {8'h00, reaction_r} :
    16'h0000;

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) CMD_RDATA_OUT <= 16'h0000;
    else CMD_RDATA_OUT <= rd_mux; // [R1] [R2] [R3] [R4]
  end

  // ---------------------------------------------------------------
  // detection and sticky status
  // ---------------------------------------------------------------
  wire signed [47:0] temp_fix = lin_fix(TEMP_IN);
  wire hot_now = temp_fix > lin_fix(hot_warn_r); // [R17]
  wire cold_now = temp_fix < lin_fix(cold_warn_r); // [R17]
  wire fault_now = temp_fix < lin_fix(cold_fault_r); // [R17]
  wire [2:0] det = {hot_now, cold_now, fault_now};
  wire [2:0] clr = STATUS_CLR_IN | {3{CLEAR_FAULTS_IN}};
  wire [2:0] status_nxt = (status_r & ~clr) | det; // [R18]

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) status_r <= '0;
    else status_r <= temp_limit_pkg::status_s'(status_nxt); // [R18]
  end

  // ---------------------------------------------------------------
  // reaction fields and clear events
  // ---------------------------------------------------------------
  wire [1:0] sel = reaction_r[temp_limit_pkg::SEL_HI:temp_limit_pkg::SEL_LO];
  wire [2:0] retry = reaction_r[temp_limit_pkg::RETRY_HI:temp_limit_pkg::RETRY_LO];
  wire [2:0] delay = reaction_r[temp_limit_pkg::DELAY_HI:temp_limit_pkg::DELAY_LO];
  wire on_rise = OUTPUT_ON_IN && !on_d_r;
  wire clear_any = CLEAR_FAULTS_IN || STATUS_CLR_IN.cold_fault || on_rise; // [R9]
  wire endless = retry == temp_limit_pkg::RETRY_ENDLESS;
  wire last_try = !endless && ({1'b0, attempts_r} + 4'h1 >= {1'b0, retry});
  wire off_to_latch = retry == temp_limit_pkg::RETRY_NONE; // [R10]
  wire tdone;

  // ---------------------------------------------------------------
  // reaction state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    attempts_nxt = attempts_r;
    tstart = 1'b0;
    case (state_r)
      temp_limit_pkg::ST_RUN: begin
        if (fault_now && OUTPUT_ON_IN && !OTHER_SHUTDOWN_IN) begin
          case (sel)
            temp_limit_pkg::SEL_IGNORE: state_nxt = temp_limit_pkg::ST_RUN; // [R5]
            temp_limit_pkg::SEL_GRACE: begin
              state_nxt = temp_limit_pkg::ST_GRACE; // [R6]
              tstart = 1'b1;
            end
            temp_limit_pkg::SEL_DISABLE: begin
              attempts_nxt = 3'h0;
              if (off_to_latch) begin
                state_nxt = temp_limit_pkg::ST_LATCH; // [R7] [R10]
              end else begin
                state_nxt = temp_limit_pkg::ST_WAIT; // [R7]
                tstart = 1'b1;
              end
            end
            default: state_nxt = temp_limit_pkg::ST_LATCH; // [R8]
          endcase
        end
      end
      temp_limit_pkg::ST_GRACE: begin
        if (!OUTPUT_ON_IN) begin
          state_nxt = temp_limit_pkg::ST_RUN;
        end else if (tdone) begin
          attempts_nxt = 3'h0;
          if (!fault_now) begin
            state_nxt = temp_limit_pkg::ST_RUN; // [R6]
          end else if (off_to_latch) begin
            state_nxt = temp_limit_pkg::ST_LATCH; // [R6] [R10]
          end else begin
            state_nxt = temp_limit_pkg::ST_WAIT; // [R6]
            tstart = 1'b1;
          end
        end
      end
      temp_limit_pkg::ST_WAIT: begin
        if (clear_any || !OUTPUT_ON_IN) begin
          state_nxt = temp_limit_pkg::ST_RUN; // [R9] [R15]
        end else if (OTHER_SHUTDOWN_IN) begin
          state_nxt = temp_limit_pkg::ST_LATCH; // [R15]
        end else if (tdone) begin
          if (!fault_now) begin
            state_nxt = temp_limit_pkg::ST_RUN;
          end else if (last_try) begin
            state_nxt = temp_limit_pkg::ST_LATCH; // [R11] [R12] [R14]
          end else begin
            attempts_nxt = endless ? attempts_r : attempts_r + 3'h1; // [R15]
            tstart = 1'b1; // [R13]
          end
        end
      end
      temp_limit_pkg::ST_LATCH: begin
        if (clear_any) state_nxt = temp_limit_pkg::ST_RUN; // [R8] [R9]
      end
      default: state_nxt = temp_limit_pkg::ST_RUN;
    endcase
  end

  wire on_state_nxt = state_nxt == temp_limit_pkg::ST_RUN ||
    state_nxt == temp_limit_pkg::ST_GRACE;

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      state_r <= temp_limit_pkg::ST_RUN;
      attempts_r <= 3'h0;
      on_d_r <= OUTPUT_ON_IN;
      en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      attempts_r <= attempts_nxt;
      on_d_r <= OUTPUT_ON_IN;
      en_r <= on_state_nxt && OUTPUT_ON_IN && !OTHER_SHUTDOWN_IN; // [R7] [R8]
    end
  end

  retry_timer u_timer (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .start_in(tstart),
    .code_in(delay),
    .unit_cycles_in(TIME_UNIT_IN),
    .done_out(tdone),
    .busy_out()
  );

  assign STATUS_OUT = status_r;
  assign OUTPUT_ENABLE_OUT = en_r;
  assign FAULT_LATCHED_OUT = state_r == temp_limit_pkg::ST_LATCH;
  assign RETRYING_OUT = state_r == temp_limit_pkg::ST_WAIT;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);

  a_hot_limit_write: assert property (wr_hot |=> hot_warn_r == $past(CMD_WDATA_IN)) // [R1]
    else $error("hot warning limit not stored");
  a_cold_warn_read: assert property ( // [R2]
    CMD_CODE_IN == temp_limit_pkg::CODE_COLD_WARN && !CMD_WR_IN |=>
    CMD_RDATA_OUT == cold_warn_r)
    else $error("cold warning limit read back wrong");
  a_react_upper_zero: assert property ( // [R4]
    CMD_CODE_IN == temp_limit_pkg::CODE_REACTION |=> CMD_RDATA_OUT[15:8] == 8'h00)
    else $error("reaction read upper byte not zero");
  a_ignore_stays_run: assert property ( // [R5]
    state_r == temp_limit_pkg::ST_RUN && sel == temp_limit_pkg::SEL_IGNORE &&
    !wr_react |=> state_r == temp_limit_pkg::ST_RUN)
    else $error("ignore selector left run state");
  a_grace_keeps_on: assert property ( // [R6]
    state_r == temp_limit_pkg::ST_GRACE && OUTPUT_ON_IN && !OTHER_SHUTDOWN_IN &&
    !tdone |=> OUTPUT_ENABLE_OUT)
    else $error("output dropped during grace delay");
  a_disable_at_once: assert property ( // [R7]
    state_r == temp_limit_pkg::ST_RUN && fault_now && OUTPUT_ON_IN &&
    sel == temp_limit_pkg::SEL_DISABLE |=> !OUTPUT_ENABLE_OUT)
    else $error("disable selector did not drop output");
  a_latch_holds_off: assert property ( // [R8]
    FAULT_LATCHED_OUT && !clear_any |=> FAULT_LATCHED_OUT && !OUTPUT_ENABLE_OUT)
    else $error("latched fault released without clear");
  a_clear_frees_latch: assert property ( // [R9]
    FAULT_LATCHED_OUT && CLEAR_FAULTS_IN |=> state_r == temp_limit_pkg::ST_RUN)
    else $error("clear did not release latch");
  a_zero_retry_latch: assert property ( // [R10]
    state_r == temp_limit_pkg::ST_RUN && fault_now && OUTPUT_ON_IN &&
    !OTHER_SHUTDOWN_IN && sel == temp_limit_pkg::SEL_DISABLE &&
    off_to_latch |=> FAULT_LATCHED_OUT)
    else $error("zero retries did not latch");
  a_retry_limit_latch: assert property ( // [R11] [R12] [R14]
    RETRYING_OUT && tdone && fault_now && last_try && OUTPUT_ON_IN &&
    !clear_any && !OTHER_SHUTDOWN_IN |=> FAULT_LATCHED_OUT)
    else $error("retry budget spent but not latched");
  a_endless_retry: assert property ( // [R15]
    RETRYING_OUT && tdone && fault_now && endless && OUTPUT_ON_IN &&
    !clear_any && !OTHER_SHUTDOWN_IN |=> RETRYING_OUT)
    else $error("endless retry stopped");
  a_fault_sticky: assert property ( // [R17] [R18]
    fault_now |=> STATUS_OUT.cold_fault)
    else $error("cold fault status not set");
  a_fault_status_clear: assert property ( // [R18]
    STATUS_OUT.cold_fault && CLEAR_FAULTS_IN && !fault_now |=> !STATUS_OUT.cold_fault)
    else $error("cold fault status not cleared");
  a_grace_to_wait: assert property ( // [R6]
    state_r == temp_limit_pkg::ST_GRACE && OUTPUT_ON_IN && tdone && fault_now &&
    !off_to_latch |=> RETRYING_OUT)
    else $error("grace end with fault did not start retries");
  a_wait_off_run: assert property ( // [R15]
    RETRYING_OUT && !OUTPUT_ON_IN |=> !RETRYING_OUT && !FAULT_LATCHED_OUT)
    else $error("off command did not stop retries");
  a_shutdown_latch: assert property ( // [R15]
    RETRYING_OUT && OUTPUT_ON_IN && OTHER_SHUTDOWN_IN && !clear_any |=> FAULT_LATCHED_OUT)
    else $error("other shutdown did not latch");

  c_grace_path: cover property (state_r == temp_limit_pkg::ST_GRACE ##1
    state_r == temp_limit_pkg::ST_WAIT);
  c_retry_recover: cover property (RETRYING_OUT ##1 state_r == temp_limit_pkg::ST_RUN);
  c_latch_cleared: cover property (FAULT_LATCHED_OUT ##1 !FAULT_LATCHED_OUT);
  c_endless_hold: cover property (RETRYING_OUT && endless ##1 RETRYING_OUT);
  c_shutdown_latch: cover property (RETRYING_OUT && OTHER_SHUTDOWN_IN ##1 FAULT_LATCHED_OUT);
endmodule

// file: hw/temp_limit_pkg.sv
// constants, types and register map of the temperature limit bank
package temp_limit_pkg;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_HOT_WARN = 8'h51;
  localparam logic [7:0] CODE_COLD_WARN = 8'h52;
  localparam logic [7:0] CODE_COLD_FAULT = 8'h53;
  localparam logic [7:0] CODE_REACTION = 8'h54;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] HOT_WARN_RST = 16'h0000;
  localparam logic [15:0] COLD_WARN_RST = 16'h0000;
  localparam logic [15:0] COLD_FAULT_RST = 16'h0000;
  localparam logic [7:0] REACTION_RST = 8'h00;
  // ---------------------------------------------------------------
  // reaction fields
  // ---------------------------------------------------------------
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] SEL_IGNORE = 2'h0;
  localparam logic [1:0] SEL_GRACE = 2'h1;
  localparam logic [1:0] SEL_DISABLE = 2'h2;
  localparam logic [1:0] SEL_LATCH = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_GRACE = 2'b01,
    ST_WAIT = 2'b10,
    ST_LATCH = 2'b11
  } react_e;
  typedef struct packed {
    logic hot_warn;
    logic cold_warn;
    logic cold_fault;
  } status_s;
endpackage

// file: verif/pmbus_host_model.sv
// host side model driving the command port and clear strobes
`timescale 1ns/100ps
module pmbus_host_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic [7:0] code_out,
  output logic wr_out,
  output logic [15:0] wdata_out,
  output logic clear_out,
  output temp_limit_pkg::status_s status_clr_out
);
  initial begin
    code_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 16'h0000;
    clear_out = 1'b0;
    status_clr_out = 3'h0;
  end
  // one write, then one idle cycle
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    code_out = code;
    wdata_out = data;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    wdata_out = ~data;
    @(posedge clk_in);
    #1;
  endtask
  // code sampled at one edge, data valid after it
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    code_out = code;
    @(posedge clk_in);
    #1;
    data = rdata_in;
  endtask
  // clear strobes for one cycle
  task automatic pulse(input temp_limit_pkg::status_s clr, input logic all);
    status_clr_out = clr;
    clear_out = all;
    @(posedge clk_in);
    #1;
    status_clr_out = 3'h0;
    clear_out = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
endmodule

// file: verif/testbench.sv
// self-checking bench of the temperature limit bank
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic on = 1'b1;
  logic shut = 1'b0;
  logic [15:0] temp = 16'h0019;
  logic [15:0] unit = 16'h0001;
  logic [7:0] code;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic clear;
  temp_limit_pkg::status_s sclr;
  temp_limit_pkg::status_s status;
  logic en;
  logic latched;
  logic retrying;
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [15:0] T_OK = 16'h0019;
  localparam logic [15:0] T_HI = 16'h0060;
  localparam logic [15:0] T_COOL = 16'h0004;
  localparam logic [15:0] T_COLD = 16'h0001;
  always #2.5 clk = ~clk;
  temp_limit_bank temp_limit_bank_inst (
    .REF_CLK_IN(clk), .RST_IN(rst), .CMD_CODE_IN(code), .CMD_WR_IN(wr),
    .CMD_WDATA_IN(wdata), .CMD_RDATA_OUT(rdata), .CLEAR_FAULTS_IN(clear),
    .STATUS_CLR_IN(sclr), .OUTPUT_ON_IN(on), .OTHER_SHUTDOWN_IN(shut),
    .TEMP_IN(temp), .TIME_UNIT_IN(unit), .STATUS_OUT(status),
    .OUTPUT_ENABLE_OUT(en), .FAULT_LATCHED_OUT(latched), .RETRYING_OUT(retrying)
  );
  pmbus_host_model pmbus_host_model_inst (
    .clk_in(clk), .rdata_in(rdata), .code_out(code), .wr_out(wr),
    .wdata_out(wdata), .clear_out(clear), .status_clr_out(sclr)
  );
  // ---------------------------------------------------------------
  // compare and helper tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_data({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic cmp_count(input int got, input int exp);
    cmp_data(got[15:0], exp[15:0]);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] d;
    pmbus_host_model_inst.rd(c, d);
    cmp_data(d, exp);
  endtask
  task automatic recover();
    temp = T_OK;
    pmbus_host_model_inst.pulse(3'h0, 1'b1);
    tick(2);
    cmp_bit(en, 1'b1);
    cmp_bit(latched, 1'b0);
  endtask
  // cold fault with persisting fault, count cycles spent waiting to restart
  task automatic run_fault(input logic [7:0] react, input logic [15:0] u, input int exp);
    int cnt;
    int i;
    cnt = 0;
    unit = u;
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_REACTION, {8'h00, react});
    temp = T_COLD;
    for (i = 0; i < 2000 && latched !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (retrying === 1'b1) cnt++;
    end
    if (latched !== 1'b1) begin
      bad_count++;
      final_report();
    end
    cmp_count(cnt, exp);
    cmp_bit(en, 1'b0);
    recover();
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    int cnt;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(1);
    for (k = 0; k < 5; k++) rd_chk(8'h51 + k[7:0], 16'h0000);
    $display("test reset_values done");
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_HOT_WARN, 16'h0050);
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_COLD_WARN, 16'h0005);
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_COLD_FAULT, 16'h0002);
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_REACTION, 16'hA5C3);
    pmbus_host_model_inst.wr(8'h55, 16'h1234);
    rd_chk(8'h51, 16'h0050);
    rd_chk(8'h52, 16'h0005);
    rd_chk(8'h53, 16'h0002);
    rd_chk(8'h54, 16'h00C3);
    rd_chk(8'h55, 16'h0000);
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_REACTION, 16'h0000);
    $display("test register_access done");
    pmbus_host_model_inst.pulse(3'h7, 1'b0);
    cmp_data({13'h0000, status}, 16'h0000);
    temp = T_HI;
    tick(1);
    temp = T_OK;
    tick(3);
    cmp_data({13'h0000, status}, 16'h0004);
    pmbus_host_model_inst.pulse(3'h4, 1'b0);
    cmp_data({13'h0000, status}, 16'h0000);
    temp = T_COOL;
    tick(1);
    cmp_data({13'h0000, status}, 16'h0002);
    temp = T_COLD;
    tick(8);
    cmp_data({13'h0000, status}, 16'h0003);
    cmp_bit(en, 1'b1);
    recover();
    $display("test status_ignore done");
    for (k = 0; k < 7; k++) run_fault({2'b10, k[2:0], 3'h1}, 16'h0002, 4 * k);
    for (k = 0; k < 8; k++) run_fault({2'b10, 3'h1, k[2:0]}, 16'h0001, 1 << k);
    run_fault(8'h92, 16'h0003, 24);
    run_fault(8'h88, 16'h0000, 1);
    run_fault(8'h48, 16'h0001, 1);
    $display("test retries done");
    for (k = 0; k < 4; k++) begin
      pmbus_host_model_inst.wr(temp_limit_pkg::CODE_REACTION, 16'h00C0);
      temp = T_COLD;
      tick(3);
      temp = T_OK;
      tick(4);
      cmp_bit(en, 1'b0);
      cmp_bit(latched, 1'b1);
      cmp_bit(retrying, 1'b0);
      if (k == 0) pmbus_host_model_inst.pulse(3'h0, 1'b1);
      if (k == 1) pmbus_host_model_inst.pulse(3'h1, 1'b0);
      if (k == 2) begin
        on = 1'b0;
        tick(2);
        on = 1'b1;
      end
      if (k == 3) begin
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
      end
      tick(2);
      cmp_bit(latched, 1'b0);
      cmp_bit(en, 1'b1);
    end
    rd_chk(8'h54, 16'h0000);
    rd_chk(8'h53, 16'h0000);
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_HOT_WARN, 16'h0050);
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_COLD_WARN, 16'h0005);
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_COLD_FAULT, 16'h0002);
    $display("test latch_clear done");
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_REACTION, 16'h00B8);
    temp = T_COLD;
    tick(200);
    cmp_bit(latched, 1'b0);
    cmp_bit(retrying, 1'b1);
    on = 1'b0;
    tick(2);
    cmp_bit(retrying, 1'b0);
    cmp_bit(en, 1'b0);
    on = 1'b1;
    tick(3);
    shut = 1'b1;
    tick(3);
    cmp_bit(latched, 1'b1);
    shut = 1'b0;
    recover();
    $display("test endless done");
    pmbus_host_model_inst.wr(temp_limit_pkg::CODE_REACTION, 16'h0042);
    temp = T_COLD;
    tick(2);
    temp = T_OK;
    tick(8);
    cmp_bit(en, 1'b1);
    cmp_bit(latched, 1'b0);
    recover();
    temp = T_COLD;
    cnt = 0;
    for (k = 0; k < 100 && latched !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      if (en === 1'b1) cnt++;
    end
    if (latched !== 1'b1) begin
      bad_count++;
      final_report();
    end
    cmp_count(cnt, 4);
    recover();
    $display("test grace done");
    final_report();
  end
endmodule
